/* File: mcs_params.svh */
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH
// Function
// - Supply result is 10 bits; low bits at 0x03, high byte at 0x06.
// - Unmasked out-of-limit supply result sets a flag in status register 0x10.
// - Interrupt output is active while any unmasked flag stands; polarity configurable.
// - Supply code is scaled so that 7 V reads as full scale 3FF.
// - Converter always uses the internal 2.28 V reference for all channels.
// - Reference amplifier is powered only while monitoring is enabled.
// - DAC reference is the external one after power-up.
// - Power-up gives round-robin mode with monitoring disabled.
// - Writing one to bit 0 of register 0x18 starts conversions.
// - Round robin converts supply, internal, external, then repeats forever.
// - Bit 4 of register 0x19 leaves round robin for single-channel mode.
// - Single mode: select zero picks supply, channel_select_low picks internal.
// - Single mode restarts the selected channel right after each conversion.
// - Serial traffic halts conversions; they resume when the transaction ends.
// - Temperatures are 10-bit twos complement at 0.25 degree per LSB.
// - Offset register is added to each internal temperature sample.
// - Temperature results are averages of 16 consecutive samples.
// - Each stored temperature is compared with its channel's high and low limits.
// - Out of limit means above the high limit or at or below the low.
// - Reading low bits first freezes the matching high bytes until any high byte is read.
`define MCS_A_STAT1 8'h00
`define MCS_A_LOW_IS 8'h03
`define MCS_A_LOW_EX 8'h04
`define MCS_A_SUP_MSB 8'h06
`define MCS_A_INT_MSB 8'h07
`define MCS_A_EXT_MSB 8'h08
`define MCS_A_STAT2 8'h10
`define MCS_A_SETUP1 8'h18
`define MCS_A_SETUP2 8'h19
`define MCS_A_DACREF 8'h1B
`define MCS_A_MASK1 8'h1C
`define MCS_A_MASK2 8'h1D
`define MCS_A_OFFSET 8'h1E
`define MCS_A_SUP_HI 8'h25
`define MCS_A_SUP_LO 8'h26
`define MCS_A_INT_HI 8'h27
`define MCS_A_INT_LO 8'h28
`define MCS_A_EXT_HI 8'h29
`define MCS_A_EXT_LO 8'h2A
`define MCS_B_ENABLE 0
`define MCS_B_POLARITY 6
`define MCS_B_SINGLE 4
`define MCS_B_AVG_OFF 5
`define MCS_B_FLAG_INT 0
`define MCS_B_FLAG_EXT 1
`define MCS_B_FLAG_SUP 0
`define MCS_B_DAC_INT 0
`define MCS_R_ZERO 8'h00
`define MCS_R_SUP_HI 8'hFF
`define MCS_R_SUP_LO 8'h00
`define MCS_R_TMP_HI 8'h7F
`define MCS_R_TMP_LO 8'h80
`define MCS_AVG_LAST 4'hF
`endif

/* File: mcs_pkg.sv */
`default_nettype none
package mcs_pkg;
  typedef enum logic [1:0] {
    CH_SUPPLY = 2'h0,
    CH_INTERNAL = 2'h1,
    CH_EXTERNAL = 2'h2
  } mcs_chan_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CONV = 3'h2,
    ST_HALT = 3'h4
  } mcs_state_t;
  function automatic mcs_chan_t mcs_rr_next(input mcs_chan_t c);
    case (c)
      CH_SUPPLY: mcs_rr_next = CH_INTERNAL;
      CH_INTERNAL: mcs_rr_next = CH_EXTERNAL;
      default: mcs_rr_next = CH_SUPPLY;
    endcase
  endfunction : mcs_rr_next
  function automatic mcs_chan_t mcs_single_chan(input logic [2:0] sel);
    if (sel[0]) mcs_single_chan = CH_INTERNAL;
    else if (sel[1]) mcs_single_chan = CH_EXTERNAL;
    else mcs_single_chan = CH_SUPPLY;
  endfunction : mcs_single_chan
endpackage : mcs_pkg
`default_nettype wire

/* File: mcs_avg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mcs_avg_if;
  logic take;
  logic [9:0] sample;
  logic bypass;
  logic done;
  logic [9:0] result;
  modport feed(output take, output sample, output bypass, input done, input result);
  modport calc(input take, input sample, input bypass, output done, output result);
endinterface : mcs_avg_if
`default_nettype wire

/* File: mcs_avg.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mcs_params.svh"
module mcs_avg (
  input wire logic i_clock,
  input wire logic i_reset,
  mcs_avg_if.calc port
);
  logic [3:0] cnt, next_cnt;
  logic signed [13:0] sum, next_sum, add;
  logic done, next_done;
  logic [9:0] res, next_res;

  // The sum of 16 signed 10-bit samples fits 14 bits, so no saturation is needed.
  always_comb begin
    add = sum + 14'($signed(port.sample));
    next_cnt = cnt;
    next_sum = sum;
    next_done = 1'b0;
    next_res = res;
    if (port.take) begin
      if (port.bypass) begin
        next_res = port.sample;
        next_done = 1'b1;
        next_cnt = 4'h0;
        next_sum = 14'sh0;
      end else if (cnt == `MCS_AVG_LAST) begin
        next_res = add[13:4];
        next_done = 1'b1;
        next_cnt = 4'h0;
        next_sum = 14'sh0;
      end else begin
        next_sum = add;
        next_cnt = cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      cnt <= 4'h0;
      sum <= 14'sh0;
      done <= 1'b0;
      res <= 10'h000;
    end else begin
      cnt <= next_cnt;
      sum <= next_sum;
      done <= next_done;
      res <= next_res;
    end
  end

  assign port.done = done;
  assign port.result = res;

  avg_window_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (port.take && !port.bypass && cnt != `MCS_AVG_LAST) |=> !done)
    else $error("average produced before sixteen samples");
endmodule : mcs_avg
`default_nettype wire

/* File: mcs_monitor_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mcs_params.svh"
module mcs_monitor_sequencer (
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_WRITE,
  input wire logic I_REG_READ,
  input wire logic I_SERIAL_BUSY,
  input wire logic I_CONV_DONE,
  input wire logic [9:0] I_CONV_CODE,
  output logic [7:0] O_REG_RDATA,
  output logic O_CONV_START,
  output var mcs_pkg::mcs_chan_t O_CONV_CHANNEL,
  output logic O_ADC_REF_INTERNAL,
  output logic O_REF_AMP_ON,
  output logic O_DAC_REF_INTERNAL,
  output logic O_INT
);
  import mcs_pkg::*;

  logic [7:0] setup1, next_setup1, setup2, next_setup2;
  logic [7:0] mask1, next_mask1, mask2, next_mask2, offset, next_offset;
  logic [7:0] sup_hi, next_sup_hi, sup_lo, next_sup_lo;
  logic [7:0] int_hi, next_int_hi, int_lo, next_int_lo;
  logic [7:0] ext_hi, next_ext_hi, ext_lo, next_ext_lo;
  logic next_dac_ref, next_amp;
  mcs_state_t state, next_state;
  mcs_chan_t next_chan;
  logic next_start, mon_en, single, sample_take;
  logic [9:0] sup_res, next_sup_res, int_res, next_int_res, ext_res, next_ext_res;
  logic [7:0] sup_msb, next_sup_msb, int_msb, next_int_msb, ext_msb, next_ext_msb;
  logic lock_is, next_lock_is, lock_ex, next_lock_ex;
  logic [1:0] stat1, next_stat1, set1;
  logic stat2, next_stat2, set2;
  logic sup_evt, sup_out, int_out, ext_out, rd, msb_rd, active;
  logic [7:0] next_rdata;
  logic next_irq;

  mcs_avg_if int_if();
  mcs_avg_if ext_if();

  function automatic logic temp_out(input logic [9:0] r, input logic [7:0] hi,
                                    input logic [7:0] lo);
    // Limits are eight bits, so only the upper eight result bits take part.
    temp_out = ($signed(r[9:2]) > $signed(hi)) || ($signed(r[9:2]) <= $signed(lo));
  endfunction : temp_out

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_setup1 = setup1;
    next_setup2 = setup2;
    next_mask1 = mask1;
    next_mask2 = mask2;
    next_offset = offset;
    next_sup_hi = sup_hi;
    next_sup_lo = sup_lo;
    next_int_hi = int_hi;
    next_int_lo = int_lo;
    next_ext_hi = ext_hi;
    next_ext_lo = ext_lo;
    next_dac_ref = O_DAC_REF_INTERNAL;
    if (I_REG_WRITE) begin
      case (I_REG_ADDR)
        `MCS_A_SETUP1: next_setup1 = I_REG_WDATA;
        `MCS_A_SETUP2: next_setup2 = I_REG_WDATA;
        `MCS_A_DACREF: next_dac_ref = I_REG_WDATA[`MCS_B_DAC_INT];
        `MCS_A_MASK1: next_mask1 = I_REG_WDATA;
        `MCS_A_MASK2: next_mask2 = I_REG_WDATA;
        `MCS_A_OFFSET: next_offset = I_REG_WDATA;
        `MCS_A_SUP_HI: next_sup_hi = I_REG_WDATA;
        `MCS_A_SUP_LO: next_sup_lo = I_REG_WDATA;
        `MCS_A_INT_HI: next_int_hi = I_REG_WDATA;
        `MCS_A_INT_LO: next_int_lo = I_REG_WDATA;
        `MCS_A_EXT_HI: next_ext_hi = I_REG_WDATA;
        `MCS_A_EXT_LO: next_ext_lo = I_REG_WDATA;
        default: ;
      endcase
    end
    next_amp = next_setup1[`MCS_B_ENABLE];
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      setup1 <= `MCS_R_ZERO;
      setup2 <= `MCS_R_ZERO;
      mask1 <= `MCS_R_ZERO;
      mask2 <= `MCS_R_ZERO;
      offset <= `MCS_R_ZERO;
      sup_hi <= `MCS_R_SUP_HI;
      sup_lo <= `MCS_R_SUP_LO;
      int_hi <= `MCS_R_TMP_HI;
      int_lo <= `MCS_R_TMP_LO;
      ext_hi <= `MCS_R_TMP_HI;
      ext_lo <= `MCS_R_TMP_LO;
      O_DAC_REF_INTERNAL <= 1'b0;
      O_REF_AMP_ON <= 1'b0;
      O_ADC_REF_INTERNAL <= 1'b1;
    end else begin
      setup1 <= next_setup1;
      setup2 <= next_setup2;
      mask1 <= next_mask1;
      mask2 <= next_mask2;
      offset <= next_offset;
      sup_hi <= next_sup_hi;
      sup_lo <= next_sup_lo;
      int_hi <= next_int_hi;
      int_lo <= next_int_lo;
      ext_hi <= next_ext_hi;
      ext_lo <= next_ext_lo;
      O_DAC_REF_INTERNAL <= next_dac_ref;
      O_REF_AMP_ON <= next_amp;
      // The monitor never lets the DAC reference choice reach the converter.
      O_ADC_REF_INTERNAL <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign mon_en = setup1[`MCS_B_ENABLE];
  assign single = setup2[`MCS_B_SINGLE];
  assign sample_take = (state == ST_CONV) && I_CONV_DONE && !I_SERIAL_BUSY;

  // A halted conversion is abandoned and the same channel is started afresh.
  always_comb begin
    next_state = state;
    next_chan = O_CONV_CHANNEL;
    next_start = 1'b0;
    case (state)
      ST_IDLE: begin
        if (mon_en && !I_SERIAL_BUSY) begin
          next_state = ST_CONV;
          next_start = 1'b1;
          if (single) next_chan = mcs_single_chan(setup2[2:0]);
        end
      end
      ST_CONV: begin
        if (I_SERIAL_BUSY) begin
          next_state = ST_HALT;
        end else if (!mon_en) begin
          next_state = ST_IDLE;
        end else if (I_CONV_DONE) begin
          next_start = 1'b1;
          if (single) next_chan = mcs_single_chan(setup2[2:0]);
          else next_chan = mcs_rr_next(O_CONV_CHANNEL);
        end
      end
      ST_HALT: begin
        if (!I_SERIAL_BUSY) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      state <= ST_IDLE;
      O_CONV_CHANNEL <= CH_SUPPLY;
      O_CONV_START <= 1'b0;
    end else begin
      state <= next_state;
      O_CONV_CHANNEL <= next_chan;
      O_CONV_START <= next_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign int_if.take = sample_take && (O_CONV_CHANNEL == CH_INTERNAL);
  assign int_if.sample = I_CONV_CODE + {{2{offset[7]}}, offset};
  assign int_if.bypass = setup2[`MCS_B_AVG_OFF];
  assign ext_if.take = sample_take && (O_CONV_CHANNEL == CH_EXTERNAL);
  assign ext_if.sample = I_CONV_CODE;
  assign ext_if.bypass = setup2[`MCS_B_AVG_OFF];

  mcs_avg u_int_avg (
    .i_clock(I_CLOCK),
    .i_reset(I_RESET),
    .port(int_if.calc)
  );

  mcs_avg u_ext_avg (
    .i_clock(I_CLOCK),
    .i_reset(I_RESET),
    .port(ext_if.calc)
  );

  always_comb begin
    sup_evt = sample_take && (O_CONV_CHANNEL == CH_SUPPLY);
    // The supply code arrives already scaled, 7 V being full scale.
    next_sup_res = sup_evt ? I_CONV_CODE : sup_res;
    next_int_res = int_if.done ? int_if.result : int_res;
    next_ext_res = ext_if.done ? ext_if.result : ext_res;
    sup_out = (next_sup_res[9:2] > sup_hi) || (next_sup_res[9:2] <= sup_lo);
    int_out = temp_out(next_int_res, int_hi, int_lo);
    ext_out = temp_out(next_ext_res, ext_hi, ext_lo);
    rd = I_REG_READ;
    msb_rd = rd && ((I_REG_ADDR == `MCS_A_SUP_MSB) || (I_REG_ADDR == `MCS_A_INT_MSB) ||
                    (I_REG_ADDR == `MCS_A_EXT_MSB));
    next_lock_is = lock_is;
    next_lock_ex = lock_ex;
    if (msb_rd) begin
      next_lock_is = 1'b0;
      next_lock_ex = 1'b0;
    end else if (rd && (I_REG_ADDR == `MCS_A_LOW_IS)) begin
      next_lock_is = 1'b1;
    end else if (rd && (I_REG_ADDR == `MCS_A_LOW_EX)) begin
      next_lock_ex = 1'b1;
    end
    next_sup_msb = next_lock_is ? sup_msb : next_sup_res[9:2];
    next_int_msb = next_lock_is ? int_msb : next_int_res[9:2];
    next_ext_msb = next_lock_ex ? ext_msb : next_ext_res[9:2];
    // A new event in the same cycle as the clearing read survives.
    set1[`MCS_B_FLAG_INT] = int_if.done && int_out && !mask1[`MCS_B_FLAG_INT];
    set1[`MCS_B_FLAG_EXT] = ext_if.done && ext_out && !mask1[`MCS_B_FLAG_EXT];
    set2 = sup_evt && sup_out && !mask2[`MCS_B_FLAG_SUP];
    next_stat1 = ((rd && (I_REG_ADDR == `MCS_A_STAT1)) ? 2'h0 : stat1) | set1;
    next_stat2 = ((rd && (I_REG_ADDR == `MCS_A_STAT2)) ? 1'b0 : stat2) | set2;
    active = |(stat1 & ~mask1[1:0]) || (stat2 && !mask2[`MCS_B_FLAG_SUP]);
    next_irq = active ? setup1[`MCS_B_POLARITY] : !setup1[`MCS_B_POLARITY];
    next_rdata = O_REG_RDATA;
    if (rd) begin
      case (I_REG_ADDR)
        `MCS_A_STAT1: next_rdata = {6'h00, stat1};
        `MCS_A_LOW_IS: next_rdata = {4'h0, int_res[1:0], sup_res[1:0]};
        `MCS_A_LOW_EX: next_rdata = {6'h00, ext_res[1:0]};
        `MCS_A_SUP_MSB: next_rdata = sup_msb;
        `MCS_A_INT_MSB: next_rdata = int_msb;
        `MCS_A_EXT_MSB: next_rdata = ext_msb;
        `MCS_A_STAT2: next_rdata = {7'h00, stat2};
        `MCS_A_SETUP1: next_rdata = setup1;
        `MCS_A_SETUP2: next_rdata = setup2;
        `MCS_A_DACREF: next_rdata = {7'h00, O_DAC_REF_INTERNAL};
        `MCS_A_MASK1: next_rdata = mask1;
        `MCS_A_MASK2: next_rdata = mask2;
        `MCS_A_OFFSET: next_rdata = offset;
        `MCS_A_SUP_HI: next_rdata = sup_hi;
        `MCS_A_SUP_LO: next_rdata = sup_lo;
        `MCS_A_INT_HI: next_rdata = int_hi;
        `MCS_A_INT_LO: next_rdata = int_lo;
        `MCS_A_EXT_HI: next_rdata = ext_hi;
        `MCS_A_EXT_LO: next_rdata = ext_lo;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      sup_res <= 10'h000;
      int_res <= 10'h000;
      ext_res <= 10'h000;
      sup_msb <= 8'h00;
      int_msb <= 8'h00;
      ext_msb <= 8'h00;
      lock_is <= 1'b0;
      lock_ex <= 1'b0;
      stat1 <= 2'h0;
      stat2 <= 1'b0;
      O_INT <= 1'b1;
      O_REG_RDATA <= 8'h00;
    end else begin
      sup_res <= next_sup_res;
      int_res <= next_int_res;
      ext_res <= next_ext_res;
      sup_msb <= next_sup_msb;
      int_msb <= next_int_msb;
      ext_msb <= next_ext_msb;
      lock_is <= next_lock_is;
      lock_ex <= next_lock_ex;
      stat1 <= next_stat1;
      stat2 <= next_stat2;
      O_INT <= next_irq;
      O_REG_RDATA <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);

  sequence rr_done_s;
    sample_take && mon_en && !single;
  endsequence
  sequence sup_out_s;
    sup_evt && sup_out && !mask2[`MCS_B_FLAG_SUP];
  endsequence

  int_level_a: assert property (active |=> (O_INT == $past(setup1[`MCS_B_POLARITY])))
    else $error("interrupt pin not at active level");
  amp_power_a: assert property (O_REF_AMP_ON == setup1[`MCS_B_ENABLE])
    else $error("reference amplifier power differs from enable");
  adc_ref_a: assert property (O_CONV_START |-> O_ADC_REF_INTERNAL)
    else $error("conversion without internal reference");
  idle_quiet_a: assert property (!mon_en |=> !O_CONV_START)
    else $error("conversion started while monitoring disabled");
  enable_start_a: assert property ((state == ST_IDLE && mon_en && !I_SERIAL_BUSY)
    |=> O_CONV_START && (state == ST_CONV))
    else $error("enable did not start a conversion");
  rr_order_a: assert property (rr_done_s |=> O_CONV_START &&
    (O_CONV_CHANNEL == mcs_rr_next($past(O_CONV_CHANNEL))))
    else $error("round robin order broken");
  single_chan_a: assert property ((sample_take && mon_en && single) |=> O_CONV_START &&
    (O_CONV_CHANNEL == mcs_single_chan($past(setup2[2:0]))))
    else $error("single channel not restarted at once");
  halt_serial_a: assert property (I_SERIAL_BUSY |=> !O_CONV_START [*1] ##0
    (state != ST_CONV || $past(state) == ST_CONV))
    else $error("conversion started during serial traffic");
  supply_flag_a: assert property (sup_out_s |=> stat2 ##1 (O_INT ==
    $past(setup1[`MCS_B_POLARITY]) || $past(mask2[`MCS_B_FLAG_SUP])))
    else $error("supply limit flag not raised");
  temp_flag_a: assert property ((int_if.done && int_out && !mask1[`MCS_B_FLAG_INT])
    |=> stat1[`MCS_B_FLAG_INT])
    else $error("internal limit flag not raised");
  lock_hold_a: assert property ((lock_is && !msb_rd) |=> $stable(sup_msb) &&
    $stable(int_msb))
    else $error("locked high byte changed");
endmodule : mcs_monitor_sequencer
`default_nettype wire

/* File: mcs_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mcs_conv_model (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_start,
  input wire mcs_pkg::mcs_chan_t i_channel,
  input wire logic [9:0] i_code_sup,
  input wire logic [9:0] i_code_int,
  input wire logic [9:0] i_code_ext,
  input wire logic [3:0] i_delay,
  output logic o_done,
  output logic [9:0] o_code
);
  import mcs_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  logic running;
  logic [3:0] cnt;
  mcs_chan_t ch;
  // A new start always restarts the count, which models the converter reset on abort.
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      running <= 1'b0;
      cnt <= 4'h0;
      ch <= CH_SUPPLY;
      o_done <= 1'b0;
      o_code <= 10'h155;
    end else begin
      o_done <= 1'b0;
      // The code is only valid with done, so it is scrambled right after.
      if (o_done) o_code <= ~o_code;
      if (i_start) begin
        running <= 1'b1;
        cnt <= i_delay;
        ch <= i_channel;
      end else if (running && cnt == 4'h0) begin
        running <= 1'b0;
        o_done <= 1'b1;
        o_code <= (ch == CH_SUPPLY) ? i_code_sup : (ch == CH_INTERNAL) ? i_code_int : i_code_ext;
      end else if (running) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : mcs_conv_model
`default_nettype wire

/* File: tb_monitor_channel_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_monitor_channel_sequencer;
  import mcs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic busy = 1'b0;
  logic done;
  logic [9:0] code;
  logic [7:0] rdata;
  logic start;
  logic adc_ref;
  logic amp_on;
  logic dac_ref;
  logic irq;
  mcs_chan_t chan;
  mcs_chan_t got;
  logic [9:0] code_sup = 10'h325;
  logic [9:0] code_int = 10'h064;
  logic [9:0] code_ext = 10'h360;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  ////////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  mcs_monitor_sequencer DUT (.I_CLOCK(clk), .I_RESET(rst), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .I_REG_WRITE(wr), .I_REG_READ(rd), .I_SERIAL_BUSY(busy),
    .I_CONV_DONE(done), .I_CONV_CODE(code), .O_REG_RDATA(rdata), .O_CONV_START(start),
    .O_CONV_CHANNEL(chan), .O_ADC_REF_INTERNAL(adc_ref), .O_REF_AMP_ON(amp_on),
    .O_DAC_REF_INTERNAL(dac_ref), .O_INT(irq));
  mcs_conv_model conv (.i_clock(clk), .i_reset(rst), .i_start(start), .i_channel(chan),
    .i_code_sup(code_sup), .i_code_int(code_int), .i_code_ext(code_ext), .i_delay(4'h3),
    .o_done(done), .o_code(code));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // The ceiling is more than twenty times the length of the whole sequence.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    // An idle edge comes first, so a strobe just lowered is never raised in the same step.
    tick(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask : reg_wr
  // Read data is taken a full cycle after the strobe, where it stands until the next read.
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    check(what, {2'b00, rdata}, {2'b00, exp});
  endtask : reg_chk
  task automatic wait_start(output mcs_chan_t c);
    n = 0;
    while (start !== 1'b1 && n < 50) begin
      tick(1);
      n = n + 1;
    end
    c = chan;
    check("start seen", 10'(start), 10'h001);
    tick(1);
  endtask : wait_start
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    check("adc ref", 10'(adc_ref), 10'h001);
    check("amp off", 10'(amp_on), 10'h000);
    check("dac ref", 10'(dac_ref), 10'h000);
    check("irq idle", 10'(irq), 10'h001);
    n = 0;
    repeat (20) begin
      tick(1);
      if (start === 1'b1) n = n + 1;
    end
    check("idle starts", 10'(n), 10'h000);
    reg_chk(8'h19, 8'h00, "mode reset");
    reg_chk(8'h05, 8'h00, "unmapped read");
  endtask : t_reset_values
  task automatic t_round_robin;
    reg_wr(8'h18, 8'h01);
    tick(1);
    check("amp on", 10'(amp_on), 10'h001);
    wait_start(got);
    check("rr first", 10'(got), 10'(CH_SUPPLY));
    wait_start(got);
    check("rr second", 10'(got), 10'(CH_INTERNAL));
    wait_start(got);
    check("rr third", 10'(got), 10'(CH_EXTERNAL));
    wait_start(got);
    check("rr wrap", 10'(got), 10'(CH_SUPPLY));
  endtask : t_round_robin
  task automatic t_supply_lock;
    tick(40);
    reg_chk(8'h06, 8'hC9, "supply high byte");
    reg_chk(8'h03, 8'h01, "supply low bits");
    code_sup = 10'h16E;
    tick(60);
    reg_chk(8'h06, 8'hC9, "frozen high byte");
    reg_chk(8'h06, 8'h5B, "unlocked high byte");
  endtask : t_supply_lock
  task automatic t_limits;
    reg_wr(8'h25, 8'h5B);
    reg_chk(8'h10, 8'h00, "flag clear read");
    tick(40);
    reg_chk(8'h10, 8'h00, "equal high no flag");
    check("irq idle low pol", 10'(irq), 10'h001);
    reg_wr(8'h25, 8'h5A);
    tick(40);
    check("irq active low", 10'(irq), 10'h000);
    reg_chk(8'h10, 8'h01, "supply flag");
    reg_wr(8'h18, 8'h41);
    tick(40);
    check("irq active high", 10'(irq), 10'h001);
    reg_wr(8'h1D, 8'h01);
    reg_chk(8'h10, 8'h01, "flag before mask");
    tick(40);
    reg_chk(8'h10, 8'h00, "masked flag");
    check("irq masked", 10'(irq), 10'h000);
    reg_wr(8'h25, 8'hFF);
  endtask : t_limits
  task automatic t_single;
    reg_wr(8'h19, 8'h10);
    // A start launched at the write edge still follows the old round-robin order.
    tick(1);
    repeat (3) begin
      wait_start(got);
      check("single supply", 10'(got), 10'(CH_SUPPLY));
    end
    n = 0;
    while (done !== 1'b1 && n < 50) begin
      tick(1);
      n = n + 1;
    end
    tick(1);
    check("no gap start", 10'(start), 10'h001);
    check("no gap chan", 10'(chan), 10'(CH_SUPPLY));
  endtask : t_single
  task automatic t_temperature;
    reg_wr(8'h1E, 8'h04);
    reg_wr(8'h28, 8'h1A);
    reg_wr(8'h19, 8'h11);
    wait_start(got);
    wait_start(got);
    check("single internal", 10'(got), 10'(CH_INTERNAL));
    tick(300);
    reg_chk(8'h07, 8'h1A, "internal high byte");
    // The supply half of this register still holds the low bits of the last supply code.
    reg_chk(8'h03, 8'h02, "internal low bits");
    reg_chk(8'h00, 8'h01, "internal low flag");
  endtask : t_temperature
  task automatic t_halt;
    busy = 1'b1;
    tick(2);
    n = 0;
    repeat (20) begin
      tick(1);
      if (start === 1'b1) n = n + 1;
    end
    check("halted starts", 10'(n), 10'h000);
    busy = 1'b0;
    wait_start(got);
    check("resume chan", 10'(got), 10'(CH_INTERNAL));
    check("resume delay", 10'(n < 5), 10'h001);
  endtask : t_halt
  task automatic t_bypass;
    reg_wr(8'h1E, 8'h08);
    reg_wr(8'h19, 8'h31);
    tick(30);
    reg_chk(8'h07, 8'h1A, "still frozen high byte");
    reg_chk(8'h07, 8'h1B, "unaveraged internal");
  endtask : t_bypass
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(4);
    rst = 1'b0;
    t_reset_values();
    t_round_robin();
    t_supply_lock();
    t_limits();
    t_single();
    t_temperature();
    t_halt();
    t_bypass();
    print_verdict();
  end
endmodule : tb_monitor_channel_sequencer
`default_nettype wire
